// *** rtt_pkg.sv ***
// Constants and types of the reader timer block
// Assumes a 50 MHz system clock and byte-wide registers on a 32-bit bus
package rtt_pkg;

  // Clock rates in kHz
  localparam int unsigned SYS_CLK_KHZ    = 50000;
  localparam int unsigned BASE_TICK_KHZ  = 13560;
  localparam int unsigned SLOW_TICK_KHZ  = 212;
  localparam int unsigned ACC_W          = 17;
  localparam logic [ACC_W-1:0] ACC_MOD   = ACC_W'(SYS_CLK_KHZ);
  localparam logic [ACC_W-1:0] BASE_STEP = ACC_W'(BASE_TICK_KHZ);
  localparam logic [ACC_W-1:0] SLOW_STEP = ACC_W'(SLOW_TICK_KHZ);

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL   = 8'h19;
  localparam logic [7:0] IDX_RELOAD_HI = 8'h1a;
  localparam logic [7:0] IDX_RELOAD_LO = 8'h1b;
  localparam logic [7:0] IDX_COUNT_HI  = 8'h1c;
  localparam logic [7:0] IDX_COUNT_LO  = 8'h1d;
  localparam logic [7:0] IDX_STATUS    = 8'h30;
  localparam int unsigned ADDR_W       = 10;

  // Control fields
  localparam int unsigned CTL_STOP_RX   = 7;
  localparam int unsigned CTL_START_LO  = 4;
  localparam int unsigned CTL_RELOAD_EN = 3;
  localparam int unsigned CTL_SRC_LO    = 0;
  localparam logic [7:0]  CTL_WR_MASK   = 8'hbb;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  localparam logic [15:0] RELOAD_RESET  = 16'h0000;

  // Status fields
  localparam int unsigned STS_FLAG    = 0;
  localparam int unsigned STS_RUNNING = 1;
  localparam int unsigned STS_STOP    = 2;

  typedef enum logic [1:0] {
    START_NONE    = 2'h0,
    START_TX_END  = 2'h1,
    START_TRIM    = 2'h2,
    START_TRIM_UF = 2'h3
  } rtt_start_e;

  typedef enum logic [1:0] {
    SRC_BASE  = 2'h0,
    SRC_SLOW  = 2'h1,
    SRC_SIB_A = 2'h2,
    SRC_SIB_B = 2'h3
  } rtt_src_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK  = 2'h1
  } rtt_bus_e;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } rtt_avs_req_s;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } rtt_avs_rsp_s;

  typedef struct packed {
    logic             stop_on_receive;
    rtt_start_e       auto_start_select;
    logic             auto_reload_enable;
    rtt_src_e         tick_source_select;
  } rtt_ctl_s;

  typedef struct packed {
    rtt_ctl_s          ctl;
    logic [7:0]        reload_high_byte;
    logic [7:0]        reload_low_byte;
    logic [15:0]       count;
    logic              running;
    logic              underflow_flag;
    logic [ACC_W-1:0]  base_acc;
    logic [ACC_W-1:0]  slow_acc;
    logic [2:0]        lfo_sync;
    logic              lfo_level;
    rtt_bus_e          bus;
    rtt_avs_rsp_s      rsp;
  } rtt_state_s;

endpackage

// *** rtt_timer.sv ***
// 16-bit down-counting reader timer with Avalon-MM register slave
// Assumes transceiver and sibling timer events are one-cycle pulses on this clock;
// the oscillator reference comes from a pin and is synchronised here
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
module rtt_timer
(
  // Clock and reset
  input  wire logic                        REF_CLK_IN,
  input  wire logic                        RST_B_IN,
  // Avalon-MM slave
  input  wire logic [rtt_pkg::ADDR_W-1:0]  AVS_ADDRESS_IN,
  input  wire logic                        AVS_READ_IN,
  input  wire logic                        AVS_WRITE_IN,
  input  wire logic [31:0]                 AVS_WRITEDATA_IN,
  input  wire logic [3:0]                  AVS_BYTEENABLE_IN,
  output logic                             AVS_WAITREQUEST_OUT,
  output logic [31:0]                      AVS_READDATA_OUT,
  // Transceiver and sibling events, reference oscillator
  input  wire logic                        TX_END_IN,
  input  wire logic                        RX_FIRST_BITS_IN,
  input  wire logic                        SIB_A_UNDERFLOW_IN,
  input  wire logic                        SIB_B_UNDERFLOW_IN,
  input  wire logic                        LFO_REF_IN,
  // Timer state
  output logic                             UNDERFLOW_FLAG_OUT,
  output logic                             RUNNING_OUT
);
  import rtt_pkg::*;

  rtt_state_s   st_r;
  rtt_state_s   st_nxt;
  rtt_avs_req_s req;

  // Register index from a byte address
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction

  // Phase accumulator step, wraps modulo the system rate
  function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] acc, input logic [ACC_W-1:0] step);
    logic [ACC_W-1:0] sum;
    sum = acc + step;
    if (sum >= ACC_MOD)
    begin
      acc_step = {1'b1, sum - ACC_MOD};
    end
    else
    begin
      acc_step = {1'b0, sum};
    end
  endfunction

  // Control byte to fields; reserved bits dropped
  function automatic rtt_ctl_s ctl_unpack(input logic [7:0] b);
    rtt_ctl_s c;
    c.stop_on_receive    = b[CTL_STOP_RX];
    c.auto_start_select  = rtt_start_e'(b[CTL_START_LO +: 2]);
    c.auto_reload_enable = b[CTL_RELOAD_EN];
    c.tick_source_select = rtt_src_e'(b[CTL_SRC_LO +: 2]);
    ctl_unpack = c;
  endfunction

  // Fields to control byte; reserved bits read zero
  function automatic logic [7:0] ctl_pack(input rtt_ctl_s c);
    logic [7:0] b;
    b                    = 8'h00;
    b[CTL_STOP_RX]       = c.stop_on_receive;
    b[CTL_START_LO +: 2] = c.auto_start_select;
    b[CTL_RELOAD_EN]     = c.auto_reload_enable;
    b[CTL_SRC_LO +: 2]   = c.tick_source_select;
    ctl_pack = b & CTL_WR_MASK;
  endfunction

  // Both trimming modes share the reference edge handling
  function automatic logic is_trim(input rtt_start_e m);
    is_trim = (m == START_TRIM) || (m == START_TRIM_UF);
  endfunction

  // 16-bit reload value from its two bytes
  function automatic logic [15:0] reload_value(input rtt_state_s s);
    reload_value = {s.reload_high_byte, s.reload_low_byte};
  endfunction

  // Count tick from the selected source
  function automatic logic tick_pick(input rtt_src_e s, input logic base_t, input logic slow_t,
                                     input logic sib_a, input logic sib_b);
    logic t;
    t = 1'b0;
    case (s)
      SRC_BASE:
      begin
        t = base_t;
      end
      SRC_SLOW:
      begin
        t = slow_t;
      end
      SRC_SIB_A:
      begin
        t = sib_a;
      end
      SRC_SIB_B:
      begin
        t = sib_b;
      end
      default:
      begin
        t = 1'b0;
      end
    endcase
    tick_pick = t;
  endfunction

  // Read value of one register index
  function automatic logic [7:0] read_byte(input logic [7:0] i, input rtt_state_s s);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      IDX_CONTROL:
      begin
        b = ctl_pack(s.ctl);
      end
      IDX_RELOAD_HI:
      begin
        b = s.reload_high_byte;
      end
      IDX_RELOAD_LO:
      begin
        b = s.reload_low_byte;
      end
      IDX_COUNT_HI:
      begin
        b = s.count[15:8];
      end
      IDX_COUNT_LO:
      begin
        b = s.count[7:0];
      end
      IDX_STATUS:
      begin
        b = {6'h00, s.running, s.underflow_flag};
      end
      default:
      begin
        b = 8'h00;
      end
    endcase
    read_byte = b;
  endfunction

  assign req.address    = AVS_ADDRESS_IN;
  assign req.read       = AVS_READ_IN;
  assign req.write      = AVS_WRITE_IN;
  assign req.writedata  = AVS_WRITEDATA_IN;
  assign req.byteenable = AVS_BYTEENABLE_IN;

  always_comb
  begin
    logic [ACC_W:0] base_n;
    logic [ACC_W:0] slow_n;
    logic           tick;
    logic           lfo_rise;
    logic           trim_mode;
    logic           start_ev;
    logic           stop_ev;
    logic           flag_set;
    logic           flag_clr;
    logic           acc_ok;
    logic           wr_ok;
    logic [7:0]     idx;
    logic [7:0]     rd_byte;
    base_n    = '0;
    slow_n    = '0;
    tick      = 1'b0;
    lfo_rise  = 1'b0;
    trim_mode = 1'b0;
    start_ev  = 1'b0;
    stop_ev   = 1'b0;
    flag_set  = 1'b0;
    flag_clr  = 1'b0;
    acc_ok    = 1'b0;
    wr_ok     = 1'b0;
    idx       = reg_index(req.address);
    rd_byte   = 8'h00;
    st_nxt    = st_r;

    // Reference oscillator synchroniser
    st_nxt.lfo_sync = {st_r.lfo_sync[1:0], LFO_REF_IN};
    if (st_r.lfo_sync[1] == st_r.lfo_sync[2] && st_r.lfo_sync[2] != st_r.lfo_level)
    begin
      st_nxt.lfo_level = st_r.lfo_sync[2];
      lfo_rise         = st_r.lfo_sync[2];
    end

    base_n          = acc_step(st_r.base_acc, BASE_STEP);
    st_nxt.base_acc = base_n[ACC_W-1:0];
    slow_n          = acc_step(st_r.slow_acc, SLOW_STEP);
    st_nxt.slow_acc = slow_n[ACC_W-1:0];

    tick = tick_pick(st_r.ctl.tick_source_select, base_n[ACC_W], slow_n[ACC_W],
                     SIB_A_UNDERFLOW_IN, SIB_B_UNDERFLOW_IN);

    // Bus handshake: one wait cycle, then answer
    acc_ok = (req.read || req.write) && st_r.bus == BUS_ACK;
    wr_ok  = acc_ok && req.write && req.byteenable[0];
    st_nxt.rsp.waitrequest = 1'b1;
    st_nxt.rsp.readdata    = '0;
    st_nxt.bus             = BUS_IDLE;
    if ((req.read || req.write) && st_r.bus == BUS_IDLE)
    begin
      st_nxt.bus             = BUS_ACK;
      st_nxt.rsp.waitrequest = 1'b0;
      rd_byte             = read_byte(idx, st_r);
      st_nxt.rsp.readdata = {24'h000000, rd_byte};
    end

    if (wr_ok)
    begin
      case (idx)
        IDX_CONTROL:
        begin
          st_nxt.ctl = ctl_unpack(req.writedata[7:0]);
        end
        IDX_RELOAD_HI:
        begin
          st_nxt.reload_high_byte = req.writedata[7:0];
        end
        IDX_RELOAD_LO:
        begin
          st_nxt.reload_low_byte = req.writedata[7:0];
        end
        IDX_STATUS:
        begin
          flag_clr = req.writedata[STS_FLAG];
          start_ev = req.writedata[STS_RUNNING];
          stop_ev  = req.writedata[STS_STOP];
        end
        default:
        begin
        end
      endcase
    end

    trim_mode = is_trim(st_r.ctl.auto_start_select);

    case (st_r.ctl.auto_start_select)
      START_NONE:
      begin
      end
      START_TX_END:
      begin
        start_ev = start_ev | (TX_END_IN & ~st_r.running);
      end
      START_TRIM,
      START_TRIM_UF:
      begin
        start_ev = start_ev | (lfo_rise & ~st_r.running);
        stop_ev  = stop_ev | (lfo_rise & st_r.running);
      end
      default:
      begin
      end
    endcase

    if (st_r.ctl.stop_on_receive && !trim_mode && RX_FIRST_BITS_IN)
      stop_ev = 1'b1;

    if (st_r.running && tick)
    begin
      if (st_r.count > 16'h0001)
      begin
        st_nxt.count = st_r.count - 16'h0001;
      end
      else if (st_r.ctl.auto_start_select == START_TRIM)
      begin
        st_nxt.count = 16'h0000;
      end
      else
      begin
        flag_set = 1'b1;
        if (st_r.ctl.auto_reload_enable)
          st_nxt.count = reload_value(st_r);
        else
        begin
          st_nxt.count   = 16'h0000;
          st_nxt.running = 1'b0;
        end
      end
    end

    if (stop_ev)
    begin
      st_nxt.running = 1'b0;
    end
    if (start_ev && !stop_ev)
    begin
      st_nxt.running = 1'b1;
      st_nxt.count   = reload_value(st_r);
    end

    // Set wins over clear
    if (flag_set)
    begin
      st_nxt.underflow_flag = 1'b1;
    end
    else if (flag_clr)
    begin
      st_nxt.underflow_flag = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      st_r                  <= '0;
      st_r.ctl              <= ctl_unpack(CTL_RESET);
      st_r.reload_high_byte <= RELOAD_RESET[15:8];
      st_r.reload_low_byte  <= RELOAD_RESET[7:0];
      st_r.rsp.waitrequest  <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign AVS_WAITREQUEST_OUT = st_r.rsp.waitrequest;
  assign AVS_READDATA_OUT    = st_r.rsp.readdata;
  assign UNDERFLOW_FLAG_OUT  = st_r.underflow_flag;
  assign RUNNING_OUT         = st_r.running;

endmodule

// *** rtt_timer_props.sv ***
// Port checker for the reader timer
// Assumes one clock domain and the control layout of rtt_pkg
`timescale 1ns/10ps
module rtt_timer_props
(
  // Clock, reset and bus
  input wire logic                       REF_CLK_IN,
  input wire logic                       RST_B_IN,
  input wire logic [rtt_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic                       AVS_WRITE_IN,
  input wire logic [31:0]                AVS_WRITEDATA_IN,
  input wire logic [3:0]                 AVS_BYTEENABLE_IN,
  input wire logic                       AVS_WAITREQUEST_OUT,
  input wire logic [31:0]                AVS_READDATA_OUT,
  // Events and state
  input wire logic                       TX_END_IN,
  input wire logic                       RX_FIRST_BITS_IN,
  input wire logic                       LFO_REF_IN,
  input wire logic                       UNDERFLOW_FLAG_OUT,
  input wire logic                       RUNNING_OUT
);
  import rtt_pkg::*;
  logic [7:0] ctl_r;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  // Shadow of the control register
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      ctl_r <= 8'h00;
    else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN[9:2] == IDX_CONTROL && AVS_BYTEENABLE_IN[0])
      ctl_r <= AVS_WRITEDATA_IN[7:0];
  end
  property p_ack_once;
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  property p_rd_idle;
    AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside ack");
  property p_no_auto;
    ctl_r[5:4] == 2'b00 && !RUNNING_OUT && !AVS_WRITE_IN |=> !RUNNING_OUT;
  endproperty
  a_no_auto: assert property (p_no_auto)
    else $error("started without request");
  property p_tx_start;
    ctl_r[5:4] == 2'b01 && !RUNNING_OUT && TX_END_IN && !AVS_WRITE_IN && !(RX_FIRST_BITS_IN && ctl_r[7])
      |=> RUNNING_OUT;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("no start at transmit end");
  property p_rx_stop;
    ctl_r[7] && !ctl_r[5] && RX_FIRST_BITS_IN |=> !RUNNING_OUT;
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("receive did not stop timer");
  property p_lfo_start;
    ctl_r[5:4] == 2'b10 && !RUNNING_OUT && $rose(LFO_REF_IN) && !AVS_WRITE_IN |-> ##[2:5] RUNNING_OUT;
  endproperty
  a_lfo_start: assert property (p_lfo_start)
    else $error("no start on reference edge");
  property p_flag_run;
    $rose(UNDERFLOW_FLAG_OUT) |-> $past(RUNNING_OUT);
  endproperty
  a_flag_run: assert property (p_flag_run)
    else $error("flag set while stopped");
  property p_stop_zero;
    $rose(UNDERFLOW_FLAG_OUT) && !ctl_r[3] |-> !RUNNING_OUT;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("kept running after underflow");
endmodule
bind rtt_timer rtt_timer_props u_props (.REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
  .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .AVS_READDATA_OUT(AVS_READDATA_OUT), .TX_END_IN(TX_END_IN), .RX_FIRST_BITS_IN(RX_FIRST_BITS_IN),
  .LFO_REF_IN(LFO_REF_IN), .UNDERFLOW_FLAG_OUT(UNDERFLOW_FLAG_OUT), .RUNNING_OUT(RUNNING_OUT));

// *** rtt_timer_tb.sv ***
// Self-checking bench for the reader timer
// Assumes the register map and one-wait-cycle bus of rtt_pkg
`timescale 1ns/10ps
module rtt_timer_tb;
  import rtt_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [31:0]       wd = '0;
  logic [3:0]        ev = 4'h0;
  logic              low_frequency_oscillator = 1'b0;
  logic [3:0]        be = 4'hf;
  logic              wait_n;
  logic [31:0]       rdat;
  logic              flag;
  logic              run;
  int                fails = 0;
  int                n_checks = 0;
  logic [31:0]       seed = 32'h324c3124;
  logic [7:0]        v;
  logic [7:0]        lo_q[$];
  logic [7:0]        hi_q[$];
  rtt_timer dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_WAITREQUEST_OUT(wait_n),
    .AVS_READDATA_OUT(rdat), .TX_END_IN(ev[0]), .RX_FIRST_BITS_IN(ev[1]), .SIB_A_UNDERFLOW_IN(ev[2]),
    .SIB_B_UNDERFLOW_IN(ev[3]), .LFO_REF_IN(low_frequency_oscillator), .UNDERFLOW_FLAG_OUT(flag), .RUNNING_OUT(run));
  always #10 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic print_verdict();
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Result watcher: oldest note against each read answer
  always @(posedge clk)
    if (rd && wait_n === 1'b0)
    begin
      n_checks++;
      if ($isunknown(rdat) || rdat[31:8] !== 24'h0 || rdat[7:0] < lo_q[0] || rdat[7:0] > hi_q[0])
      begin
        fails++;
        $display("CHECK FAILED %0t read %h at %h", $time, rdat, adr);
      end
      void'(lo_q.pop_front());
      void'(hi_q.pop_front());
    end
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [7:0] lo, hi);
    if (!w)
    begin
      lo_q.push_back(lo);
      hi_q.push_back(hi);
    end
    adr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wd <= {rnd(), rnd(), rnd(), d};
    repeat (20)
    begin
      @(posedge clk);
      if (wait_n === 1'b0)
        break;
    end
    if (wait_n !== 1'b0)
    begin
      fails++;
      $display("CHECK FAILED %0t bus timeout", $time);
      print_verdict();
    end
    else
    begin
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic w8(input logic [7:0] i, d);
    bus(1'b1, i, d, 8'h00, 8'h00);
  endtask
  task automatic r8(input logic [7:0] i, lo, hi);
    bus(1'b0, i, 8'h00, lo, hi);
  endtask
  task automatic chk_out(input logic f, input logic r);
    n_checks++;
    if (flag !== f || run !== r)
    begin
      fails++;
      $display("CHECK FAILED %0t flag %b run %b", $time, flag, run);
    end
  endtask
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask
  task automatic edge_lfo();
    low_frequency_oscillator <= 1'b0;
    repeat (6) @(posedge clk);
    low_frequency_oscillator <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic src_run(input logic [7:0] c, input int n, input logic [7:0] h, lo, hi);
    w8(IDX_CONTROL, c);
    w8(IDX_STATUS, 8'h02);
    repeat (n) @(posedge clk);
    w8(IDX_STATUS, 8'h04);
    r8(IDX_COUNT_HI, h, h);
    r8(IDX_COUNT_LO, lo, hi);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    r8(IDX_RELOAD_HI, 8'h00, 8'h00);
    v = rnd();
    w8(IDX_RELOAD_HI, v);
    r8(IDX_RELOAD_HI, v, v);
    v = rnd();
    w8(IDX_RELOAD_LO, v);
    r8(IDX_RELOAD_LO, v, v);
    be <= 4'he;
    w8(IDX_RELOAD_LO, ~v);
    be <= 4'hf;
    r8(IDX_RELOAD_LO, v, v);
    w8(IDX_CONTROL, 8'hff);
    r8(IDX_CONTROL, 8'hbb, 8'hbb);
    r8(8'h1e, 8'h00, 8'h00);
    w8(IDX_COUNT_LO, 8'h55);
    r8(IDX_COUNT_LO, 8'h00, 8'h00);
    v = (rnd() & 8'h07) + 8'h02;
    w8(IDX_RELOAD_HI, 8'h00);
    w8(IDX_RELOAD_LO, v);
    w8(IDX_CONTROL, 8'h02);
    pulse(4'h1);
    r8(IDX_STATUS, 8'h00, 8'h00);
    w8(IDX_STATUS, 8'h02);
    pulse(4'hb);
    w8(IDX_RELOAD_LO, 8'h02);
    r8(IDX_COUNT_LO, v, v);
    r8(IDX_STATUS, 8'h02, 8'h02);
    repeat (v - 8'h01) pulse(4'h4);
    r8(IDX_COUNT_LO, 8'h01, 8'h01);
    pulse(4'h4);
    r8(IDX_COUNT_LO, 8'h00, 8'h00);
    r8(IDX_STATUS, 8'h01, 8'h01);
    chk_out(1'b1, 1'b0);
    w8(IDX_CONTROL, 8'h0b);
    w8(IDX_STATUS, 8'h03);
    pulse(4'h8);
    pulse(4'h8);
    r8(IDX_COUNT_LO, 8'h02, 8'h02);
    r8(IDX_STATUS, 8'h03, 8'h03);
    w8(IDX_STATUS, 8'h05);
    w8(IDX_CONTROL, 8'h92);
    pulse(4'h1);
    r8(IDX_STATUS, 8'h02, 8'h02);
    chk_out(1'b0, 1'b1);
    pulse(4'h2);
    r8(IDX_STATUS, 8'h00, 8'h00);
    w8(IDX_CONTROL, 8'ha2);
    edge_lfo();
    pulse(4'h6);
    repeat (3) pulse(4'h4);
    r8(IDX_STATUS, 8'h02, 8'h02);
    edge_lfo();
    r8(IDX_STATUS, 8'h00, 8'h00);
    w8(IDX_CONTROL, 8'hb2);
    edge_lfo();
    pulse(4'h4);
    pulse(4'h4);
    r8(IDX_STATUS, 8'h01, 8'h01);
    chk_out(1'b1, 1'b0);
    w8(IDX_RELOAD_LO, 8'hff);
    w8(IDX_RELOAD_HI, 8'hff);
    src_run(8'h00, 1000, 8'hfe, 8'hed, 8'hf1);
    src_run(8'h01, 2400, 8'hff, 8'hf3, 8'hf6);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_out(1'b0, 1'b0);
    r8(IDX_RELOAD_LO, 8'h00, 8'h00);
    r8(IDX_CONTROL, 8'h00, 8'h00);
    print_verdict();
  end
endmodule
